// ---- tcs_defines.svh ----
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define TCS_CLK_CTRL_IDX   10'h08e
`define TCS_MODE_IDX       10'h090
`define TCS_TMR0_IDX       10'h091
`define TCS_TMR3_IDX       10'h094
`define TCS_INT_STS_IDX    10'h098
`define TCS_INT_MSK_IDX    10'h099

// ---------------------------------------------------------------
// Reset values and widths
// ---------------------------------------------------------------
`define TCS_CLK_CTRL_RST   8'h00
`define TCS_MODE_W         21
`define TCS_MODE_RST       21'h000000
`define TCS_INT_W          9
`define TCS_INT_RST        9'h000
`define TCS_TMR_RST        32'h00000000

// ---------------------------------------------------------------
// Clock control fields
// ---------------------------------------------------------------
`define TCS_CC_PSC_LSB     0
`define TCS_CC_T0_SYS      2
`define TCS_CC_T1_SYS      3
`define TCS_CC_T2_LO       4
`define TCS_CC_T2_HI       5

// ---------------------------------------------------------------
// Mode register fields
// ---------------------------------------------------------------
`define TCS_MD_T01_STRIDE  4
`define TCS_MD_T01_CNT     2
`define TCS_MD_T01_RUN     3
`define TCS_MD_T23_BASE    8
`define TCS_MD_T23_STRIDE  5
`define TCS_MD_T23_CAP     1
`define TCS_MD_T23_RUN     2
`define TCS_MD_T23_XSEL    3

// ---------------------------------------------------------------
// Interrupt bits
// ---------------------------------------------------------------
`define TCS_INT_T0_HI      1
`define TCS_INT_T23_LO     3
`define TCS_INT_CAP2       7

// ---------------------------------------------------------------
// Divider terminal counts and synchronised pin count
// ---------------------------------------------------------------
`define TCS_DIV12_LAST     4'hb
`define TCS_DIV4_LAST      2'h3
`define TCS_DIV48_LAST     2'h3
`define TCS_DIV8_LAST      3'h7
`define TCS_PIN_N          6

`endif

// ---- tcs_pkg.sv ----
`default_nettype none
package tcs_pkg;
   typedef enum logic [1:0] {
      PSC_DIV12 = 2'b00,
      PSC_DIV4  = 2'b01,
      PSC_DIV48 = 2'b10,
      PSC_EXT8  = 2'b11
   } tcs_psc_e;
   typedef enum logic [1:0] {
      T01_13BIT   = 2'b00,
      T01_16BIT   = 2'b01,
      T01_RELOAD8 = 2'b10,
      T01_SPLIT   = 2'b11
   } tcs_t01_mode_e;
   typedef enum logic [1:0] {
      XS_DIV12 = 2'b00,
      XS_ALT8  = 2'b01,
      XS_CMP   = 2'b10,
      XS_RSVD  = 2'b11
   } tcs_xsel_e;
   typedef struct packed {
      logic [15:0] reload;
      logic [15:0] count;
   } tcs_tmr_s;
endpackage
`default_nettype wire

// ---- tcs_timer_clock_source_select.sv ----
// Decided for this implementation: the AXI4-Lite register port.
`include "tcs_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tcs_timer_clock_source_select
   import tcs_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        counter0_event_pin,
   input  wire logic        counter1_event_pin,
   input  wire logic        rtc_osc_clk,
   input  wire logic        ext_osc_clk,
   input  wire logic        cmp0_out,
   input  wire logic        cmp1_out,
   output logic             irq
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] wmerge(
      input logic [31:0] old,
      input logic [31:0] dat,
      input logic [3:0]  stb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (stb[b]) begin
            r[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [17:0] t01_step(
      input tcs_t01_mode_e md,
      input logic [15:0]   c,
      input logic          tl,
      input logic          th);
      logic [12:0] v13;
      logic [15:0] n;
      logic        olo;
      logic        ohi;
      v13 = {c[15:8], c[4:0]} + 13'h0001;
      n = c;
      olo = 1'b0;
      ohi = 1'b0;
      case (md)
         T01_13BIT: begin
            olo = tl & (&{c[15:8], c[4:0]});
            if (tl) begin
               n = {v13[12:5], c[7:5], v13[4:0]};
            end
         end
         T01_16BIT: begin
            olo = tl & (&c);
            if (tl) begin
               n = c + 16'h0001;
            end
         end
         T01_RELOAD8: begin
            olo = tl & (&c[7:0]);
            if (tl) begin
               n[7:0] = (&c[7:0]) ? c[15:8] : c[7:0] + 8'h01;
            end
         end
         default: begin
            olo = tl & (&c[7:0]);
            ohi = th & (&c[15:8]);
            if (tl) begin
               n[7:0] = c[7:0] + 8'h01;
            end
            if (th) begin
               n[15:8] = c[15:8] + 8'h01;
            end
         end
      endcase
      return {ohi, olo, n};
   endfunction

   function automatic logic [34:0] t23_step(
      input logic     split,
      input logic     cap,
      input logic     evt,
      input tcs_tmr_s t,
      input logic     tl,
      input logic     th);
      tcs_tmr_s n;
      logic     olo;
      logic     ohi;
      logic     cf;
      n = t;
      olo = 1'b0;
      ohi = 1'b0;
      cf = 1'b0;
      if (cap) begin
         olo = tl & (&t.count);
         if (tl) begin
            n.count = t.count + 16'h0001;
         end
         if (evt) begin
            n.reload = t.count;
            cf = 1'b1;
         end
      end else if (split) begin
         olo = tl & (&t.count[7:0]);
         ohi = th & (&t.count[15:8]);
         if (tl) begin
            n.count[7:0] = (&t.count[7:0]) ? t.reload[7:0]
                                           : t.count[7:0] + 8'h01;
         end
         if (th) begin
            n.count[15:8] = (&t.count[15:8]) ? t.reload[15:8]
                                             : t.count[15:8] + 8'h01;
         end
      end else begin
         olo = tl & (&t.count);
         if (tl) begin
            n.count = (&t.count) ? t.reload : t.count + 16'h0001;
         end
      end
      return {cf, ohi, olo, n};
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [`TCS_PIN_N-1:0] pin_raw;
   logic [`TCS_PIN_N-1:0] s1_q;
   logic [`TCS_PIN_N-1:0] s2_q;
   logic [`TCS_PIN_N-1:0] s3_q;
   logic [`TCS_PIN_N-1:0] stb_q;
   logic [`TCS_PIN_N-1:0] stb_d;
   logic [`TCS_PIN_N-1:0] fall;
   logic [`TCS_PIN_N-1:0] rise;

   assign pin_raw = {cmp1_out, cmp0_out, ext_osc_clk, rtc_osc_clk,
                     counter1_event_pin, counter0_event_pin};

   for (genvar i = 0; i < `TCS_PIN_N; i++) begin : g_sync
      assign stb_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : stb_q[i];
      assign fall[i]  = stb_q[i] & ~stb_d[i];
      assign rise[i]  = ~stb_q[i] & stb_d[i];
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            s1_q[i]  <= 1'b0;
            s2_q[i]  <= 1'b0;
            s3_q[i]  <= 1'b0;
            stb_q[i] <= 1'b0;
         end else begin
            s1_q[i]  <= pin_raw[i];
            s2_q[i]  <= s1_q[i];
            s3_q[i]  <= s2_q[i];
            stb_q[i] <= stb_d[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Clock dividers
   // ---------------------------------------------------------------
   logic [3:0] c12_q;
   logic [3:0] c12_d;
   logic [1:0] c48_q;
   logic [1:0] c48_d;
   logic [2:0] r8_q;
   logic [2:0] r8_d;
   logic [2:0] e8_q;
   logic [2:0] e8_d;
   logic       tick12;
   logic       tick4;
   logic       tick48;
   logic       rtc8;
   logic       ext8;

   always_comb begin
      tick12 = (c12_q == `TCS_DIV12_LAST);
      tick4  = (c12_q[1:0] == `TCS_DIV4_LAST);
      tick48 = tick12 & (c48_q == `TCS_DIV48_LAST);
      c12_d  = tick12 ? 4'h0 : c12_q + 4'h1;
      c48_d  = tick12 ? c48_q + 2'h1 : c48_q;
      rtc8   = rise[2] & (r8_q == `TCS_DIV8_LAST);
      r8_d   = rise[2] ? r8_q + 3'h1 : r8_q;
      ext8   = rise[3] & (e8_q == `TCS_DIV8_LAST);
      e8_d   = rise[3] ? e8_q + 3'h1 : e8_q;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c12_q <= 4'h0;
         c48_q <= 2'h0;
         r8_q  <= 3'h0;
         e8_q  <= 3'h0;
      end else begin
         c12_q <= c12_d;
         c48_q <= c48_d;
         r8_q  <= r8_d;
         e8_q  <= e8_d;
      end
   end

   // ---------------------------------------------------------------
   // Bus slave and timers
   // ---------------------------------------------------------------
   logic                  aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [11:0]           awaddr_q, awaddr_d;
   logic [31:0]           wdata_q, wdata_d;
   logic [3:0]            wstrb_q, wstrb_d;
   logic                  awready_q, awready_d, wready_q, wready_d;
   logic                  bvalid_q, bvalid_d, arready_q, arready_d;
   logic                  rvalid_q, rvalid_d;
   logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]           rdata_q, rdata_d;
   logic [7:0]            cc_q, cc_d;
   logic [`TCS_MODE_W-1:0] md_q, md_d;
   tcs_tmr_s              tmr_q [4];
   tcs_tmr_s              tmr_d [4];
   logic [`TCS_INT_W-1:0] sts_q, sts_d, msk_q, msk_d, set, clr;
   logic                  irq_q, irq_d;
   logic                  do_wr, hit, psc_tick, tl, th, bt, evt;
   logic [9:0]            widx, ridx;
   logic [31:0]           wm;
   logic [17:0]           s01;
   logic [34:0]           s23;
   int                    mb;

   always_comb begin
      aw_hold_d = aw_hold_q | (s_axi_awvalid & awready_q);
      w_hold_d  = w_hold_q | (s_axi_wvalid & wready_q);
      awaddr_d  = (s_axi_awvalid & awready_q) ? s_axi_awaddr : awaddr_q;
      wdata_d   = (s_axi_wvalid & wready_q) ? s_axi_wdata : wdata_q;
      wstrb_d   = (s_axi_wvalid & wready_q) ? s_axi_wstrb : wstrb_q;
      bvalid_d  = bvalid_q & ~s_axi_bready;
      bresp_d   = bresp_q;
      do_wr     = aw_hold_q & w_hold_q & ~bvalid_q;
      widx      = awaddr_q[11:2];
      wm        = 32'h0;
      cc_d      = cc_q;
      md_d      = md_q;
      msk_d     = msk_q;
      tmr_d     = tmr_q;
      set       = '0;
      clr       = '0;
      hit       = 1'b1;
      case (tcs_psc_e'(cc_q[`TCS_CC_PSC_LSB +: 2]))
         PSC_DIV12: psc_tick = tick12;
         PSC_DIV4:  psc_tick = tick4;
         PSC_DIV48: psc_tick = tick48;
         default:   psc_tick = ext8;
      endcase
      for (int k = 0; k < 2; k++) begin
         mb = `TCS_MD_T01_STRIDE * k;
         tl = md_q[mb + `TCS_MD_T01_RUN] &
              (md_q[mb + `TCS_MD_T01_CNT] ? fall[k]
               : (cc_q[`TCS_CC_T0_SYS + k] | psc_tick));
         th = md_q[`TCS_MD_T01_STRIDE + `TCS_MD_T01_RUN] &
              (cc_q[`TCS_CC_T1_SYS] | psc_tick);
         if (k == 1 && md_q[mb +: 2] == T01_SPLIT) begin
            tl = 1'b0;
            th = 1'b0;
         end
         s01 = t01_step(tcs_t01_mode_e'(md_q[mb +: 2]), tmr_q[k].count,
                        tl, th);
         tmr_d[k].count = s01[15:0];
         set[2*k] = s01[16];
         set[`TCS_INT_T0_HI] = set[`TCS_INT_T0_HI] | s01[17];
      end
      for (int j = 0; j < 2; j++) begin
         mb = `TCS_MD_T23_BASE + `TCS_MD_T23_STRIDE * j;
         evt = (tcs_xsel_e'(md_q[mb + `TCS_MD_T23_XSEL +: 2]) == XS_ALT8)
               ? (j == 0 ? rtc8 : ext8) : rise[4+j];
         case (tcs_xsel_e'(md_q[mb + `TCS_MD_T23_XSEL +: 2]))
            XS_ALT8: bt = evt;
            XS_CMP:  bt = rise[4+j];
            default: bt = tick12;
         endcase
         tl = md_q[mb + `TCS_MD_T23_RUN] & (cc_q[`TCS_CC_T2_LO + 2*j] |
              (md_q[mb + `TCS_MD_T23_CAP] ? tick12 : bt));
         th = md_q[mb + `TCS_MD_T23_RUN] &
              (cc_q[`TCS_CC_T2_HI + 2*j] | bt);
         s23 = t23_step(md_q[mb], md_q[mb + `TCS_MD_T23_CAP],
                        evt & md_q[mb + `TCS_MD_T23_RUN],
                        tmr_q[2+j], tl, th);
         tmr_d[2+j] = s23[31:0];
         set[`TCS_INT_T23_LO + 2*j] = s23[32];
         set[`TCS_INT_T23_LO + 2*j + 1] = s23[33];
         set[`TCS_INT_CAP2 + j] = s23[34];
      end
      if (do_wr) begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         if (widx == `TCS_CLK_CTRL_IDX) begin
            wm   = wmerge({24'h0, cc_q}, wdata_q, wstrb_q);
            cc_d = wm[7:0];
         end else if (widx == `TCS_MODE_IDX) begin
            wm   = wmerge({11'h0, md_q}, wdata_q, wstrb_q);
            md_d = wm[`TCS_MODE_W-1:0];
         end else if (widx >= `TCS_TMR0_IDX && widx <= `TCS_TMR3_IDX) begin
            wm = {22'h0, widx - `TCS_TMR0_IDX};
            tmr_d[wm[1:0]] = wmerge(tmr_q[wm[1:0]], wdata_q, wstrb_q);
         end else if (widx == `TCS_INT_STS_IDX) begin
            wm  = wmerge(32'h0, wdata_q, wstrb_q);
            clr = wm[`TCS_INT_W-1:0];
         end else if (widx == `TCS_INT_MSK_IDX) begin
            wm    = wmerge({23'h0, msk_q}, wdata_q, wstrb_q);
            msk_d = wm[`TCS_INT_W-1:0];
         end else begin
            hit = 1'b0;
         end
         bresp_d = hit ? 2'b00 : 2'b10;
      end
      awready_d = ~aw_hold_d & ~bvalid_d;
      wready_d  = ~w_hold_d & ~bvalid_d;
      sts_d     = (sts_q & ~clr) | set;
      irq_d     = |(sts_d & msk_d);
      ridx      = s_axi_araddr[11:2];
      rvalid_d  = rvalid_q & ~s_axi_rready;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (s_axi_arvalid & arready_q) begin
         rvalid_d = 1'b1;
         rresp_d  = 2'b00;
         rdata_d  = 32'h0;
         if (ridx == `TCS_CLK_CTRL_IDX) begin
            rdata_d = {24'h0, cc_q};
         end else if (ridx == `TCS_MODE_IDX) begin
            rdata_d = {11'h0, md_q};
         end else if (ridx >= `TCS_TMR0_IDX && ridx <= `TCS_TMR3_IDX) begin
            rdata_d = {22'h0, ridx - `TCS_TMR0_IDX};
            rdata_d = tmr_q[rdata_d[1:0]];
         end else if (ridx == `TCS_INT_STS_IDX) begin
            rdata_d = {23'h0, sts_q};
         end else if (ridx == `TCS_INT_MSK_IDX) begin
            rdata_d = {23'h0, msk_q};
         end else begin
            rresp_d = 2'b10;
         end
      end
      arready_d = ~rvalid_d;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 12'h000;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'b00;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= 2'b00;
         rdata_q   <= 32'h0;
         cc_q      <= `TCS_CLK_CTRL_RST;
         md_q      <= `TCS_MODE_RST;
         tmr_q     <= '{default: `TCS_TMR_RST};
         sts_q     <= `TCS_INT_RST;
         msk_q     <= `TCS_INT_RST;
         irq_q     <= 1'b0;
      end else begin
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb_q   <= wstrb_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         cc_q      <= cc_d;
         md_q      <= md_d;
         tmr_q     <= tmr_d;
         sts_q     <= sts_d;
         msk_q     <= msk_d;
         irq_q     <= irq_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign irq           = irq_q;

endmodule
`default_nettype wire

// ---- tcs_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Event and slow clock sources
// ----------------------------------------
module tcs_partner (
   input  wire logic       aclk,
   input  wire logic [5:0] en,
   output logic [5:0]      pins
);
   logic       ph_q = 1'b0;
   logic [5:0] lvl_q = 6'h00;
   assign pins = lvl_q;
   always @(posedge aclk) begin
      ph_q <= ~ph_q;
      if (ph_q) lvl_q <= lvl_q ^ en;
   end
endmodule
`default_nettype wire

// ---- tcs_timer_clock_source_select_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Register bus checks
// ----------------------------------------
module tcs_sva import tcs_pkg::*; (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic aw_ok_q;
   logic ar_ok_q;
   function automatic logic ok(input logic [11:0] a);
      return a inside {12'h238, 12'h240, 12'h244, 12'h248, 12'h24c,
                       12'h250, 12'h260, 12'h264};
   endfunction
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) aw_ok_q <= ok(s_axi_awaddr);
      if (s_axi_arvalid && s_axi_arready) ar_ok_q <= ok(s_axi_araddr);
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_follow;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_b_follow: assert property (p_b_follow) else $error("no bvalid");
   property p_b_resp;
      s_axi_bvalid |-> s_axi_bresp == (aw_ok_q ? 2'b00 : 2'b10);
   endproperty
   a_b_resp: assert property (p_b_resp) else $error("bad bresp");
   property p_b_once;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_once: assert property (p_b_once) else $error("bvalid stuck");
   property p_aw_refuse;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_refuse: assert property (p_aw_refuse) else $error("aw taken");
   property p_r_follow;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_follow: assert property (p_r_follow) else $error("no rvalid");
   property p_r_resp;
      s_axi_rvalid |-> s_axi_rresp == (ar_ok_q ? 2'b00 : 2'b10);
   endproperty
   a_r_resp: assert property (p_r_resp) else $error("bad rresp");
   property p_r_bad;
      s_axi_rvalid && !ar_ok_q |-> s_axi_rdata == 32'h00000000;
   endproperty
   a_r_bad: assert property (p_r_bad) else $error("bad rdata");
   property p_r_refuse;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_r_refuse: assert property (p_r_refuse) else $error("ar taken");
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once) else $error("rvalid stuck");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_bad: cover property (s_axi_rvalid && !ar_ok_q);
endmodule
bind tcs_timer_clock_source_select tcs_sva u_sva (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- tcs_timer_clock_source_select_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module tcs_timer_clock_source_select_bench import tcs_pkg::*; ;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   logic [5:0]  en = 6'h00, pins, last_q = 6'h00;
   int          num_errors = 0, checked = 0, b0, b2, b5;
   int          fall0 = 0, rise2 = 0, rise5 = 0;
   tcs_timer_clock_source_select dut_u (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .counter0_event_pin(pins[0]),
      .counter1_event_pin(pins[1]), .rtc_osc_clk(pins[2]),
      .ext_osc_clk(pins[3]), .cmp0_out(pins[4]), .cmp1_out(pins[5]),
      .irq);
   tcs_partner src_u (.aclk, .en, .pins);
   initial forever #2.5 aclk = ~aclk;
   // ----------------------------------------
   // Edge model
   // ----------------------------------------
   always @(posedge aclk) begin
      last_q <= pins;
      fall0 <= fall0 + int'(last_q[0] & ~pins[0]);
      rise2 <= rise2 + int'(~last_q[2] & pins[2]);
      rise5 <= rise5 + int'(~last_q[5] & pins[5]);
   end
   task automatic chk(input string n, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] x);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_bvalid) break;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_rvalid) break;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   task automatic rchk(input logic [11:0] a, input string n,
                       input logic [31:0] lo, hi);
      rd(a);
      if (lo == hi) chk(n, d, lo);
      else chk(n, 32'(d >= lo && d <= hi), 32'h1);
   endtask
   initial begin
      #200000;
      num_errors++;
      give_verdict;
   end
   initial begin
      void'($urandom(32'hf644));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(12'h238, "ctrl_rst", 32'h0, 32'h0);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         v[1:0] = 2'(i);
         wr(12'h238, v);
         rchk(12'h238, "ctrl", 32'(v[7:0]), 32'(v[7:0]));
      end
      wr(12'h3fc, v);
      chk("bresp_bad", 32'(r), 32'h2);
      rchk(12'h3fc, "rdata_bad", 32'h0, 32'h0);
      chk("rresp_bad", 32'(r), 32'h2);
      wr(12'h238, 32'h04);
      wr(12'h244, 32'h0);
      wr(12'h240, 32'h0d);
      b0 = fall0;
      en <= 6'h01;
      repeat (64) @(posedge aclk);
      en <= 6'h00;
      repeat (8) @(posedge aclk);
      wr(12'h240, 32'h0);
      rchk(12'h244, "t0_events", fall0 - b0, fall0 - b0);
      wr(12'h24c, 32'h0);
      wr(12'h250, 32'h0);
      wr(12'h244, 32'h0);
      wr(12'h238, 32'h11);
      wr(12'h240, 32'h8409);
      repeat (480) @(posedge aclk);
      wr(12'h240, 32'h0);
      rchk(12'h244, "t0_div4", 32'd119, 32'd123);
      rchk(12'h24c, "t2_sys", 32'd480, 32'd490);
      rchk(12'h250, "t3_div12", 32'd39, 32'd42);
      wr(12'h24c, 32'h0);
      wr(12'h250, 32'h0);
      wr(12'h238, 32'h0);
      b2 = rise2;
      b5 = rise5;
      wr(12'h240, 32'h28c00);
      en <= 6'h24;
      repeat (128) @(posedge aclk);
      en <= 6'h00;
      repeat (8) @(posedge aclk);
      wr(12'h240, 32'h0);
      rchk(12'h24c, "t2_rtc8", (rise2 - b2) / 8, (rise2 - b2) / 8);
      rchk(12'h250, "t3_cmp", rise5 - b5, rise5 - b5);
      wr(12'h244, 32'hfffe);
      wr(12'h238, 32'h04);
      wr(12'h240, 32'h09);
      repeat (10) @(posedge aclk);
      wr(12'h240, 32'h0);
      rchk(12'h260, "ovf_sts", 32'h1, 32'h1);
      chk("irq_masked", 32'(irq), 32'h0);
      wr(12'h264, 32'h1);
      @(posedge aclk);
      chk("irq_on", 32'(irq), 32'h1);
      wr(12'h260, 32'h1);
      @(posedge aclk);
      chk("irq_off", 32'(irq), 32'h0);
      rchk(12'h260, "sts_clr", 32'h0, 32'h0);
      wr(12'h244, 32'h0);
      wr(12'h24c, 32'h0);
      wr(12'h250, 32'h0);
      wr(12'h238, 32'h42);
      en <= 6'h10;
      wr(12'h240, 32'hb6b8);
      repeat (480) @(posedge aclk);
      en <= 6'h00;
      wr(12'h240, 32'h0);
      rchk(12'h244, "t0_div48", 32'd10, 32'd11);
      rchk(12'h248, "t1_split_stop", 32'h0, 32'h0);
      rd(12'h24c);
      chk("t2_cap", 32'(d[31:16] > 0 && d[31:16] <= d[15:0]), 32'h1);
      rd(12'h250);
      chk("t3_lo", 32'(d[7:0] inside {[8'he0:8'he6]}), 32'h1);
      chk("t3_hi", 32'(d[15:8] inside {[39:42]}), 32'h1);
      rchk(12'h260, "sts_evt", 32'ha0, 32'ha0);
      give_verdict;
   end
endmodule
`default_nettype wire
